// >>> design/sbcs_control.v
`timescale 1ns/100ps
`include "sbcs_defines.vh"

module sbcs_fifo #(
    parameter WIDTH = `SBCS_FIFO_WIDTH,
    parameter DEPTH = `SBCS_FIFO_DEPTH,
    parameter AW    = `SBCS_FIFO_AW
) (
    input  wire             clk,
    input  wire             rst_b,
    input  wire             in_valid,
    input  wire [WIDTH-1:0] in_data,
    output reg              in_ready,
    output reg              out_valid,
    output wire [WIDTH-1:0] out_data,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    reg [AW:0]      next_count;
    wire            push;
    wire            pop;

    assign push     = in_valid & in_ready;
    assign pop      = out_valid & out_ready;
    assign out_data = mem[rd_ptr];

    // occupancy after this cycle's push and pop
    always @* begin
        next_count = count;
        if (push & ~pop)
            next_count = count + {{AW{1'b0}}, 1'b1};
        else if (pop & ~push)
            next_count = count - {{AW{1'b0}}, 1'b1};
    end

    // full and empty are registered so the ready seen outside is a flop
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr    <= {AW{1'b0}};
            rd_ptr    <= {AW{1'b0}};
            count     <= {(AW+1){1'b0}};
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            if (push)
                wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
            if (pop)
                rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
            count     <= next_count;
            in_ready  <= (next_count != DEPTH[AW:0]);
            out_valid <= (next_count != {(AW+1){1'b0}});
        end
    end

    // storage needs no reset
    always @(posedge clk) begin
        if (push)
            mem[wr_ptr] <= in_data;
    end
endmodule

module sbcs_control (
    input  wire       clk,
    input  wire       rst_b,
    // special-function register port
    input  wire [3:0] sfr_page,
    input  wire [7:0] sfr_addr,
    input  wire       sfr_wr,
    input  wire [7:0] sfr_wdata,
    input  wire       sfr_rd,
    input  wire       sfr_bit_wr,
    input  wire [2:0] sfr_bit_sel,
    input  wire       sfr_bit_val,
    output reg  [7:0] sfr_rdata,
    // events from the bit engine as one-cycle pulses, plus its status, phase and mode levels
    input  wire       start_generated,
    input  wire       stop_generated,
    input  wire       start_detected,
    input  wire       stop_detected,
    input  wire       addr_received,
    input  wire       byte_received,
    input  wire       byte_sent_acked,
    input  wire       ack_cycle_done,
    input  wire       ack_in_valid,
    input  wire       ack_in,
    input  wire       frame_start,
    input  wire       addressed,
    input  wire       gen_stop_phase,
    input  wire       gen_rstart_phase,
    input  wire       sending_one,
    input  wire       auto_reply_enable,
    // bus pins, sensed only
    input  wire       scl_in,
    input  wire       sda_in,
    // requests to the bit engine
    output reg        start_req,
    output reg        stop_req,
    output reg        ack_out,
    output reg        proceed,
    output reg  [7:0] tx_data,
    output reg        tx_load,
    // clock line hold, open drain
    output reg        scl_o,
    output reg        scl_oe,
    // received byte stream
    input  wire       rx_valid,
    input  wire [7:0] rx_data,
    output wire       rx_ready
);
    reg        master;
    reg        txdir;
    reg        start_request_bit;
    reg        stop_request_bit;
    reg        reply_request_flag;
    reg        arbitration_loss_flag;
    reg        ack;
    reg        si;
    reg        tx_loaded;
    reg        ack_written;
    reg        scl_m;
    reg        scl_s;
    reg        sda_m;
    reg        sda_s;
    reg        next_si;
    reg  [7:0] wmask;
    reg  [7:0] wval;
    wire       page_ok;
    wire       ctrl_wr;
    wire       data_wr;
    wire       data_rd;
    wire       si_clear;
    wire       arb_rstart;
    wire       arb_scl;
    wire       arb_sda;
    wire       arb_stop;
    wire       arb_evt;
    wire       si_evt;
    wire       fifo_valid;
    wire [7:0] fifo_data;
    // one-hot lane of a bit index
    function [7:0] bit_lane;
        input [2:0] idx;
        begin
            bit_lane = 8'h01 << idx;
        end
    endfunction
    sbcs_fifo #(
        .WIDTH (`SBCS_FIFO_WIDTH),
        .DEPTH (`SBCS_FIFO_DEPTH),
        .AW    (`SBCS_FIFO_AW)
    ) u_rx_fifo (
        .clk       (clk),
        .rst_b     (rst_b),
        .in_valid  (rx_valid),
        .in_data   (rx_data),
        .in_ready  (rx_ready),
        .out_valid (fifo_valid),
        .out_data  (fifo_data),
        .out_ready (data_rd)
    );
    // pins come from outside the clock domain
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
        end else begin
            scl_m <= scl_in;
            scl_s <= scl_m;
            sda_m <= sda_in;
            sda_s <= sda_m;
        end
    end
    // address decode on page 0
    assign page_ok = (sfr_page == `SBCS_PAGE);
    assign ctrl_wr = page_ok & (sfr_addr == `SBCS_CTRL_ADDR);
    assign data_wr = page_ok & sfr_wr & (sfr_addr == `SBCS_DATA_ADDR);
    assign data_rd = page_ok & sfr_rd & (sfr_addr == `SBCS_DATA_ADDR)
                     & fifo_valid;
    // byte and bit writes folded into one mask and value
    always @* begin
        wmask = 8'h00;
        wval  = 8'h00;
        if (ctrl_wr & sfr_wr) begin
            wmask = 8'hFF;
            wval  = sfr_wdata;
        end else if (ctrl_wr & sfr_bit_wr) begin
            wmask = bit_lane(sfr_bit_sel);
            wval  = {8{sfr_bit_val}} & wmask;
        end
    end
    assign si_clear = wmask[`SBCS_SI_BIT] & ~wval[`SBCS_SI_BIT];
    // arbitration loss causes; pins read only after the second flop
    assign arb_rstart = start_detected & master & ~start_request_bit;
    assign arb_scl    = (gen_stop_phase | gen_rstart_phase) & ~scl_s;
    assign arb_sda    = sending_one & ~sda_s;
    assign arb_stop   = stop_detected & master;
    assign arb_evt    = arb_rstart | arb_scl | arb_sda | arb_stop;
    // the six sources of a serial event
    assign si_evt = start_generated | arb_evt | byte_sent_acked
                    | byte_received | addr_received
                    | (stop_detected & addressed);
    // hardware set wins over a clear in the same cycle
    always @* begin
        next_si = si;
        if (wmask[`SBCS_SI_BIT])
            next_si = wval[`SBCS_SI_BIT];
        if (si_evt)
            next_si = 1'b1;
    end
    // status and control bits
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            master      <= 1'b0;
            txdir       <= 1'b0;
            start_request_bit         <= 1'b0;
            stop_request_bit         <= 1'b0;
            reply_request_flag       <= 1'b0;
            arbitration_loss_flag     <= 1'b0;
            ack         <= 1'b0;
            si          <= 1'b0;
            tx_loaded   <= 1'b0;
            ack_written <= 1'b0;
        end else begin
            si <= next_si;
            // role is hardware-only; writes do not reach it
            if (start_generated)
                master <= 1'b1;
            else if (stop_generated | arb_evt)
                master <= 1'b0;
            // direction follows whether data was preloaded
            if (start_generated | (frame_start & tx_loaded))
                txdir <= 1'b1;
            else if (start_detected | arb_evt | frame_start)
                txdir <= 1'b0;
            if (data_wr)
                tx_loaded <= 1'b1;
            else if (frame_start)
                tx_loaded <= 1'b0;
            // start bit: software owns the clear
            if (wmask[`SBCS_STA_BIT])
                start_request_bit <= wval[`SBCS_STA_BIT];
            if (addr_received | start_detected)
                start_request_bit <= 1'b1;
            // stop bit: writing 1 only counts while master
            if (stop_generated)
                stop_request_bit <= 1'b0;
            else if (wmask[`SBCS_STO_BIT] & (master | ~wval[`SBCS_STO_BIT]))
                stop_request_bit <= wval[`SBCS_STO_BIT];
            if ((stop_detected & addressed) | arb_stop)
                stop_request_bit <= 1'b1;
            // reply request is raised only in software reply mode
            if (ack_cycle_done)
                reply_request_flag <= 1'b0;
            if (byte_received & ~auto_reply_enable)
                reply_request_flag <= 1'b1;
            // loss flag dies with the event flag, new loss wins
            if (si_clear)
                arbitration_loss_flag <= 1'b0;
            if (arb_evt)
                arbitration_loss_flag <= 1'b1;
            // acknowledge bit: written value or value seen on the bus
            if (wmask[`SBCS_ACK_BIT])
                ack <= wval[`SBCS_ACK_BIT];
            if (ack_in_valid)
                ack <= ~ack_in;
            // a fresh request forgets any earlier written reply
            if (byte_received & ~auto_reply_enable)
                ack_written <= 1'b0;
            else if (wmask[`SBCS_ACK_BIT])
                ack_written <= 1'b1;
        end
    end
    // requests to the engine; engine orders STOP before START
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            start_req <= 1'b0;
            stop_req  <= 1'b0;
            ack_out   <= 1'b0;
            proceed   <= 1'b0;
            tx_data   <= `SBCS_DATA_RESET;
            tx_load   <= 1'b0;
            scl_o     <= 1'b0;
            scl_oe    <= 1'b0;
        end else begin
            start_req <= start_request_bit & ~si;
            stop_req  <= stop_request_bit & master & ~si;
            // unwritten reply under a pending request means NACK
            ack_out   <= ack & (ack_written | ~reply_request_flag);
            proceed   <= si & ~next_si;
            tx_load   <= data_wr;
            if (data_wr)
                tx_data <= sfr_wdata;
            // line held low as long as the event is pending
            scl_o     <= 1'b0;
            scl_oe    <= next_si;
        end
    end
    // registered read data; unmapped reads return zero
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sfr_rdata <= `SBCS_CTRL_RESET;
        end else if (sfr_rd) begin
            if (ctrl_wr)
                sfr_rdata <= {master, txdir, start_request_bit, stop_request_bit,
                              reply_request_flag, arbitration_loss_flag, ack, si};
            else if (data_rd)
                sfr_rdata <= fifo_data;
            else
                sfr_rdata <= 8'h00;
        end
    end
endmodule

// >>> design/sbcs_defines.vh
`ifndef SBCS_DEFINES_VH
`define SBCS_DEFINES_VH

// special-function page and addresses
`define SBCS_PAGE          4'h0
`define SBCS_CTRL_ADDR     8'hC0
`define SBCS_DATA_ADDR     8'hC2

// serial_bus_control_status bit positions
`define SBCS_MASTER_BIT    3'h7
`define SBCS_TXDIR_BIT     3'h6
`define SBCS_STA_BIT       3'h5
`define SBCS_STO_BIT       3'h4
`define SBCS_REPLY_REQUEST_FLAG_BIT     3'h3
`define SBCS_ARB_BIT       3'h2
`define SBCS_ACK_BIT       3'h1
`define SBCS_SI_BIT        3'h0

// reset values
`define SBCS_CTRL_RESET    8'h00
`define SBCS_DATA_RESET    8'h00

// receive buffer shape
`define SBCS_FIFO_WIDTH    8
`define SBCS_FIFO_DEPTH    16
`define SBCS_FIFO_AW       4

`endif

// >>> verification/sbcs_bus_model.sv
`timescale 1ns/100ps
module sbcs_bus_model (
    input  wire       clk,
    input  wire       rst_b,
    input  wire       scl_oe,
    input  wire       scl_o,
    input  wire       pull_sda,
    input  wire       slow,
    input  wire       go,
    input  wire       rx_ready,
    output wire       scl_in,
    output wire       sda_in,
    output wire       rx_valid,
    output wire [7:0] rx_data
);
    reg [4:0] cnt;
    reg       gap;
    // pulled-up lines: released reads high, held clock reads low
    assign scl_in = !(scl_oe && !scl_o);
    assign sda_in = !pull_sda;
    // one byte more than the buffer holds, so it must refuse one
    assign rx_valid = go && !gap && cnt < 5'h11;
    // idle data shows the inverse, never a stale copy
    assign rx_data = rx_valid ? 8'hA0 + cnt : ~(8'hA0 + cnt);
    // a slow sender idles one cycle after each byte taken
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 5'h00;
            gap <= 1'b0;
        end else begin
            gap <= slow && rx_valid && rx_ready;
            if (rx_valid && rx_ready) begin
                cnt <= cnt + 5'h01;
            end
        end
    end
endmodule

// >>> verification/sbcs_control_chk.sv
`timescale 1ns/100ps
module sbcs_control_chk (
    input wire       clk,
    input wire       rst_b,
    input wire [3:0] sfr_page,
    input wire [7:0] sfr_addr,
    input wire       sfr_rd,
    input wire       sfr_bit_wr,
    input wire [2:0] sfr_bit_sel,
    input wire       sfr_bit_val,
    input wire [7:0] sfr_rdata,
    input wire       start_generated,
    input wire       stop_detected,
    input wire       addr_received,
    input wire       byte_received,
    input wire       byte_sent_acked,
    input wire       addressed,
    input wire       sending_one,
    input wire       sda_in,
    input wire       scl_o,
    input wire       scl_oe,
    input wire       proceed,
    input wire       sfr_wr,
    input wire [7:0] sfr_wdata,
    input wire       tx_load,
    input wire [7:0] tx_data
);
    // a hardware set beats a clear, so skip clears with one of five engine pulses active
    wire ev = start_generated | stop_detected | addr_received
        | byte_received | byte_sent_acked;
    wire si_wr = sfr_page == 4'h0 && sfr_addr == 8'hC0 && sfr_bit_wr
        && sfr_bit_sel == 3'h0;
    wire unmapped = sfr_page != 4'h0
        || (sfr_addr != 8'hC0 && sfr_addr != 8'hC2);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_low; scl_oe |-> !scl_o; endproperty
    a_low: assert property (p_low) else $error("scl driven high");
    property p_gen; start_generated |=> scl_oe; endproperty
    a_gen: assert property (p_gen) else $error("no hold on start");
    property p_byte; byte_received || byte_sent_acked |=> scl_oe; endproperty
    a_byte: assert property (p_byte) else $error("no hold on byte");
    property p_adr; addr_received || stop_detected && addressed |=> scl_oe;
    endproperty
    a_adr: assert property (p_adr) else $error("no hold on slave");
    property p_arb; (sending_one && !sda_in) [*4] |-> ##[0:3] scl_oe;
    endproperty
    a_arb: assert property (p_arb) else $error("no loss on sda");
    property p_frc; si_wr && sfr_bit_val |-> ##[1:2] scl_oe; endproperty
    a_frc: assert property (p_frc) else $error("force failed");
    property p_clr; si_wr && !sfr_bit_val && scl_oe && !ev
        |-> ##[1:2] proceed; endproperty
    a_clr: assert property (p_clr) else $error("no proceed");
    property p_rd0; sfr_rd && unmapped |=> sfr_rdata == 8'h00; endproperty
    a_rd0: assert property (p_rd0) else $error("unmapped read");
    property p_rst; $rose(rst_b) |-> sfr_rdata == 8'h00; endproperty
    a_rst: assert property (p_rst) else $error("reset value");
    property p_ld; sfr_wr && sfr_page == 4'h0 && sfr_addr == 8'hC2
        |=> tx_load && tx_data == $past(sfr_wdata); endproperty
    a_ld: assert property (p_ld) else $error("data not loaded");
    c_gen: cover property (start_generated ##1 scl_oe);
    c_clr: cover property (proceed);
    c_slv: cover property (stop_detected && addressed ##1 scl_oe);
endmodule

// >>> verification/tb_smbus_control_status_logic.sv
`timescale 1ns/100ps
module tb_smbus_control_status_logic;
    logic       clk, rst_b, sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_val;
    logic [3:0] sfr_page;
    logic [7:0] sfr_addr, sfr_wdata;
    logic [2:0] sfr_bit_sel;
    logic [9:0] evs;
    logic       ack_in, frame_start, gen_stop_phase, gen_rstart_phase;
    logic       sending_one, auto_reply_enable, pull_sda, slow, go;
    wire        addressed, ack_in_valid, start_generated, stop_generated;
    wire        start_detected, stop_detected, addr_received;
    wire        byte_received, byte_sent_acked, ack_cycle_done;
    wire        scl_in, sda_in, start_req, stop_req, ack_out, proceed;
    wire        tx_load, scl_o, scl_oe, rx_valid, rx_ready;
    wire  [7:0] sfr_rdata, tx_data, rx_data;
    int         n_fail, compares, i;
    // {addressed, ack_in_valid, eight engine pulses} and the read back
    localparam logic [17:0] ROWS [8] = '{
        {10'h080, 8'hC1}, {10'h102, 8'hC3}, {10'h040, 8'h40},
        {10'h020, 8'h20}, {10'h008, 8'h21}, {10'h004, 8'h09},
        {10'h001, 8'h00}, {10'h210, 8'h11}};
    assign {addressed, ack_in_valid, start_generated, stop_generated,
        start_detected, stop_detected, addr_received, byte_received,
        byte_sent_acked, ack_cycle_done} = evs;
    sbcs_control   i_dut (.*);
    sbcs_bus_model i_model (.*);
    always #2 clk = ~clk;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc;
        @(posedge clk);
        #1;
    endtask
    // every strobe drops for a cycle so tasks may follow back to back
    task automatic wa(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        cyc;
        sfr_wr = 1'b0;
        cyc;
    endtask
    task automatic wr(input logic [7:0] d);
        wa(8'hC0, d);
    endtask
    task automatic bw(input logic [2:0] s, input logic v);
        sfr_addr = 8'hC0;
        sfr_bit_sel = s;
        sfr_bit_val = v;
        sfr_bit_wr = 1'b1;
        cyc;
        sfr_bit_wr = 1'b0;
        cyc;
    endtask
    task automatic rd(input logic [3:0] p, input logic [7:0] a,
                      input logic [7:0] e);
        sfr_page = p;
        sfr_addr = a;
        sfr_rd = 1'b1;
        cyc;
        sfr_rd = 1'b0;
        sfr_page = 4'h0;
        cyc;
        chk(sfr_rdata, e);
    endtask
    task automatic pulse(input logic [9:0] e);
        evs = e;
        cyc;
        evs = 10'h000;
        cyc;
    endtask
    task automatic end_sim;
        if (n_fail == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        {sfr_page, sfr_addr, sfr_wdata, sfr_bit_sel, evs} = '0;
        {sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_val, ack_in} = '0;
        {frame_start, gen_stop_phase, gen_rstart_phase} = '0;
        {sending_one, auto_reply_enable, pull_sda, slow, go} = '0;
        n_fail = 0;
        compares = 0;
        repeat (20) @(posedge clk);
        #1 rst_b = 1'b1;
        rd(4'h0, 8'hC0, 8'h00);
        for (i = 0; i < 8; i++) begin
            pulse(ROWS[i][17:8]);
            rd(4'h0, 8'hC0, ROWS[i][7:0]);
            wr(8'h00);
        end
        rd(4'h1, 8'hC0, 8'h00);
        rd(4'h0, 8'hC1, 8'h00);
        // stop request as slave is refused too
        wr(8'hFF);
        rd(4'h0, 8'hC0, 8'h23);
        bw(3'h5, 1'b0);
        bw(3'h1, 1'b0);
        rd(4'h0, 8'hC0, 8'h01);
        bw(3'h0, 1'b0);
        bw(3'h0, 1'b1);
        rd(4'h0, 8'hC0, 8'h01);
        bw(3'h0, 1'b0);
        pulse(10'h080);
        bw(3'h0, 1'b0);
        wr(8'h30);
        rd(4'h0, 8'hC0, 8'hF0);
        chk({start_req, stop_req}, 8'h03);
        pulse(10'h040);
        rd(4'h0, 8'hC0, 8'h60);
        // stop seen while master counts as lost arbitration
        pulse(10'h080);
        wr(8'h00);
        pulse(10'h010);
        rd(4'h0, 8'hC0, 8'h15);
        bw(3'h0, 1'b0);
        rd(4'h0, 8'hC0, 8'h10);
        wr(8'h00);
        sending_one = 1'b1;
        pull_sda = 1'b1;
        repeat (6) cyc;
        sending_one = 1'b0;
        pull_sda = 1'b0;
        rd(4'h0, 8'hC0, 8'h05);
        wr(8'h00);
        // an ack value written before the byte must not count
        bw(3'h1, 1'b1);
        pulse(10'h004);
        bw(3'h0, 1'b0);
        chk({7'h00, ack_out}, 8'h00);
        pulse(10'h004);
        bw(3'h1, 1'b1);
        chk({7'h00, ack_out}, 8'h01);
        pulse(10'h001);
        wr(8'h00);
        // hardware reply mode never asks software for a reply
        auto_reply_enable = 1'b1;
        pulse(10'h004);
        rd(4'h0, 8'hC0, 8'h01);
        auto_reply_enable = 1'b0;
        wr(8'h00);
        // repeated start seen as master without a request
        pulse(10'h080);
        bw(3'h0, 1'b0);
        pulse(10'h020);
        rd(4'h0, 8'hC0, 8'h25);
        wr(8'h00);
        // clock held low while making a stop, then a repeated start
        for (i = 0; i < 2; i++) begin
            bw(3'h0, 1'b1);
            {gen_stop_phase, gen_rstart_phase} = i ? 2'b01 : 2'b10;
            repeat (3) cyc;
            {gen_stop_phase, gen_rstart_phase} = 2'b00;
            rd(4'h0, 8'hC0, 8'h05);
            wr(8'h00);
        end
        // preloaded data makes only the next frame a transmit one
        wa(8'hC2, 8'h5A);
        chk(tx_data, 8'h5A);
        for (i = 0; i < 2; i++) begin
            frame_start = 1'b1;
            cyc;
            frame_start = 1'b0;
            cyc;
            rd(4'h0, 8'hC0, i ? 8'h00 : 8'h40);
        end
        // reset in mid-run returns every bit to zero
        wr(8'hFF);
        rst_b = 1'b0;
        cyc;
        rst_b = 1'b1;
        chk({7'h00, scl_oe}, 8'h00);
        rd(4'h0, 8'hC0, 8'h00);
        slow = 1'b1;
        go = 1'b1;
        for (i = 0; i < 100 && rx_ready !== 1'b0; i++) cyc;
        // the slow sender idles one cycle after the last byte taken
        cyc;
        chk({7'h00, rx_ready}, 8'h00);
        if (rx_ready === 1'b0) begin
            chk({7'h00, rx_valid}, 8'h01);
            for (i = 0; i < 17; i++) rd(4'h0, 8'hC2, 8'hA0 + i[7:0]);
            rd(4'h0, 8'hC2, 8'h00);
        end
        end_sim;
    end
endmodule
bind sbcs_control sbcs_control_chk i_chk (.*);
